// ===== acs_pkg.sv
package acs_pkg;

  // ----------------------------------------------------------------
  // Register map and reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] ADDR_CONTROL = 16'h0001;
  localparam logic [15:0] ADDR_GAIN = 16'h0004;
  localparam logic [15:0] ADDR_THRESHOLD = 16'h0005;
  localparam logic [15:0] RST_CONTROL = 16'h0000;
  localparam logic [15:0] RST_GAIN = 16'hA000;
  localparam logic [15:0] RST_THRESHOLD = 16'hCCCC;

  // ----------------------------------------------------------------
  // Control word bit positions
  // ----------------------------------------------------------------
  localparam int CB_READ_THRESHOLD = 14;
  localparam int CB_READ_GAIN = 13;
  localparam int CB_READ_STATUS = 11;
  localparam int CB_RESYNC = 9;
  localparam int CB_REF_BYPASS = 7;
  localparam int CB_POWER_DOWN = 3;
  localparam int CB_LOW_POWER = 2;
  localparam int CB_REF_BUF_OFF = 1;
  localparam int CB_AMPLIFIER_DISABLE = 0;

  // ----------------------------------------------------------------
  // Status word fixed fields
  // ----------------------------------------------------------------
  localparam logic [3:0] STAT_FIXED_HI = 4'h9;
  localparam logic [2:0] STAT_FIXED_MID = 3'h2;
  localparam logic STAT_FIXED_LO = 1'b0;

  // ----------------------------------------------------------------
  // Framing and timing counts
  // ----------------------------------------------------------------
  localparam int WRITE_BITS = 32;
  localparam int FRAME_BITS = 32;
  localparam int OVER_RUN_LIMIT = 4;

  // Stored control bits that steer the analog side.
  typedef struct packed {
    logic ref_bypass;
    logic power_down_request;
    logic low_power_flag;
    logic ref_buf_off;
    logic amplifier_disable;
  } acs_ctrl_t;

  // Pending read selection for the next output frame.
  typedef struct packed {
    logic read_threshold_select;
    logic read_gain_select;
    logic read_status_select;
  } acs_rdsel_t;

endpackage

// ===== acs_regs.sv
module acs_regs import acs_pkg::*; #(
  parameter logic PART_ID_BIT = 1'b0, // Identity value, arbitrary.
  parameter int CONV_W = 24, // Conversion word width.
  parameter int STAGE1_W = 16 // First decimation stage magnitude width.
) (
  input wire logic i_ref_clk, // Master clock.
  input wire logic i_nrst, // Asynchronous reset, active low.
  input wire logic i_sclk, // Serial clock from host.
  input wire logic i_cs_n, // Serial frame select, active low.
  input wire logic i_sdi, // Serial write data.
  input wire logic [1:0] i_ratio_code, // Oversampling ratio code pins.
  input wire logic i_settled, // Filter settled, from filter.
  input wire logic signed [CONV_W-1:0] i_conv_data, // Final filter output.
  input wire logic i_conv_valid, // One-cycle conversion strobe.
  input wire logic [STAGE1_W-1:0] i_stage1_mag, // First stage magnitude.
  input wire logic i_stage1_valid, // One-cycle first stage strobe.
  input wire logic i_mod_full_scale, // Modulator sample beyond full scale.
  input wire logic i_mod_tick, // One-cycle modulator rate strobe.
  output logic o_sdo, // Serial read data.
  output logic o_output_frame_strobe, // High during an output frame.
  output logic o_ref_bypass, // Reference routed around buffer.
  output logic o_power_down, // Device power-down.
  output logic o_low_power, // Low power mode indication.
  output logic o_ref_buf_off, // Reference buffer powered down.
  output logic o_amplifier_disable, // Input amplifier off.
  output logic o_filter_resync, // One-cycle resync pulse.
  output logic o_overrange_flag // Overrange alert.
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] sclk_s;
  logic [1:0] cs_n_s;
  logic [1:0] sdi_s;
  logic [1:0] dec0_s;
  logic [1:0] dec1_s;
  logic sclk_d;

  // Two flops per pin; only the second stage is read by logic.
  // The select resets high and the clock low, their idle levels, so no
  // false edge or write bit follows the release of reset.
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sclk_s <= 2'h0;
      cs_n_s <= 2'h3;
      sdi_s <= 2'h0;
      dec0_s <= 2'h0;
      dec1_s <= 2'h0;
      sclk_d <= 1'b0;
    end else begin
      sclk_s <= {sclk_s[0], i_sclk};
      cs_n_s <= {cs_n_s[0], i_cs_n};
      sdi_s <= {sdi_s[0], i_sdi};
      dec0_s <= {dec0_s[0], i_ratio_code[0]};
      dec1_s <= {dec1_s[0], i_ratio_code[1]};
      sclk_d <= sclk_s[1];
    end
  end

  logic sclk_rise;
  logic sclk_fall;
  assign sclk_rise = sclk_s[1] & ~sclk_d;
  assign sclk_fall = ~sclk_s[1] & sclk_d;

  // ----------------------------------------------------------------
  // Serial write receiver
  // ----------------------------------------------------------------
  logic [WRITE_BITS-1:0] wr_shift;
  logic [5:0] wr_count;
  logic wr_commit;
  logic [15:0] wr_addr;
  logic [15:0] wr_data;

  // Address word then data word, MSB first on rising edges. Raising the
  // select mid-word drops the partial word, so a glitch cannot write.
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wr_shift <= '0;
      wr_count <= 6'h00;
      wr_commit <= 1'b0;
    end else begin
      wr_commit <= 1'b0;
      if (cs_n_s[1]) begin
        wr_count <= 6'h00;
      end else if (sclk_rise) begin
        wr_shift <= {wr_shift[WRITE_BITS-2:0], sdi_s[1]};
        if (wr_count == 6'(WRITE_BITS - 1)) begin
          wr_count <= 6'h00;
          wr_commit <= 1'b1;
        end else begin
          wr_count <= wr_count + 6'h01;
        end
      end
    end
  end

  assign wr_addr = wr_shift[31:16];
  assign wr_data = wr_shift[15:0];

  // ----------------------------------------------------------------
  // Control, gain and threshold registers
  // ----------------------------------------------------------------
  acs_ctrl_t ctrl;
  acs_rdsel_t rdsel;
  logic [15:0] gain;
  logic [15:0] threshold;
  logic frame_load;

  // Only the five stored bits exist; fixed-zero positions have no flop.
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ctrl <= acs_ctrl_t'(RST_CONTROL[4:0]);
    end else if (wr_commit && wr_addr == ADDR_CONTROL) begin
      ctrl.ref_bypass <= wr_data[CB_REF_BYPASS];
      ctrl.power_down_request <= wr_data[CB_POWER_DOWN];
      ctrl.low_power_flag <= wr_data[CB_LOW_POWER];
      ctrl.ref_buf_off <= wr_data[CB_REF_BUF_OFF];
      ctrl.amplifier_disable <= wr_data[CB_AMPLIFIER_DISABLE];
    end
  end

  // Digital gain and overrange threshold are plain stored words.
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      gain <= RST_GAIN;
      threshold <= RST_THRESHOLD;
    end else if (wr_commit) begin
      if (wr_addr == ADDR_GAIN) begin
        gain <= wr_data;
      end
      if (wr_addr == ADDR_THRESHOLD) begin
        threshold <= wr_data;
      end
    end
  end

  // Read selects are never stored in the control word; they wait as a
  // pending choice that the next frame consumes. A new selection in the
  // same cycle as a frame load wins so it is not lost.
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rdsel <= '0;
    end else if (wr_commit && wr_addr == ADDR_CONTROL &&
                 (wr_data[CB_READ_THRESHOLD] | wr_data[CB_READ_GAIN] |
                  wr_data[CB_READ_STATUS])) begin
      rdsel.read_threshold_select <= wr_data[CB_READ_THRESHOLD];
      rdsel.read_gain_select <= wr_data[CB_READ_GAIN];
      rdsel.read_status_select <= wr_data[CB_READ_STATUS];
    end else if (frame_load) begin
      rdsel <= '0;
    end
  end

  // Resync is a one-cycle pulse, so the bit self-clears by construction.
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_filter_resync <= 1'b0;
    end else begin
      o_filter_resync <= wr_commit && wr_addr == ADDR_CONTROL &&
                         wr_data[CB_RESYNC];
    end
  end

  // Analog control outputs; bypass only acts with the buffer off.
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_ref_bypass <= 1'b0;
      o_power_down <= 1'b0;
      o_low_power <= 1'b0;
      o_ref_buf_off <= 1'b0;
      o_amplifier_disable <= 1'b0;
    end else begin
      o_ref_bypass <= ctrl.ref_bypass & ctrl.ref_buf_off;
      o_power_down <= ctrl.power_down_request;
      o_low_power <= ctrl.low_power_flag;
      o_ref_buf_off <= ctrl.ref_buf_off;
      o_amplifier_disable <= ctrl.amplifier_disable;
    end
  end

  // ----------------------------------------------------------------
  // Overrange detection
  // ----------------------------------------------------------------
  logic cmp_over;
  logic mod_over;
  logic [2:0] over_run;

  // Compare the pre-gain first stage output, for the shortest delay.
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cmp_over <= 1'b0;
    end else if (i_stage1_valid) begin
      cmp_over <= i_stage1_mag > threshold;
    end
  end

  // Count consecutive full-scale modulator samples; the fifth sets it.
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      over_run <= 3'h0;
      mod_over <= 1'b0;
    end else if (i_mod_tick) begin
      if (!i_mod_full_scale) begin
        over_run <= 3'h0;
        mod_over <= 1'b0;
      end else if (over_run == 3'(OVER_RUN_LIMIT)) begin
        mod_over <= 1'b1;
      end else begin
        over_run <= over_run + 3'h1;
      end
    end
  end

  // Flag follows the present input, not a sticky history. A host that must
  // catch a short excursion has to watch the flag; nothing latches it.
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_overrange_flag <= 1'b0;
    end else begin
      o_overrange_flag <= cmp_over | mod_over;
    end
  end

  // ----------------------------------------------------------------
  // Status word and gain scaling
  // ----------------------------------------------------------------
  logic [15:0] status_word;
  assign status_word = {PART_ID_BIT,
                        STAT_FIXED_HI,
                        i_settled,
                        ctrl.low_power_flag,
                        o_overrange_flag,
                        STAT_FIXED_MID,
                        ctrl.ref_buf_off, ctrl.amplifier_disable,
                        STAT_FIXED_LO,
                        dec1_s[1], dec0_s[1]};

  // Unity at 0x8000: shift the product down 15 and saturate on overflow.
  // Two guard bits sit above the result, so an overflow shows as a
  // disagreement between them and the result's sign bit.
  logic signed [CONV_W+16:0] product;
  logic [CONV_W-1:0] scaled;
  assign product = i_conv_data * $signed({1'b0, gain});
  always_comb begin
    if (product[CONV_W+16:CONV_W+14] == 3'h0 ||
        product[CONV_W+16:CONV_W+14] == 3'h7) begin
      scaled = product[CONV_W+14:15];
    end else if (product[CONV_W+16]) begin
      scaled = {1'b1, {(CONV_W-1){1'b0}}};
    end else begin
      scaled = {1'b0, {(CONV_W-1){1'b1}}};
    end
  end

  // ----------------------------------------------------------------
  // Output frame transmitter
  // ----------------------------------------------------------------
  logic [FRAME_BITS-1:0] tx_shift;
  logic [5:0] tx_count;
  logic [FRAME_BITS-1:0] next_frame;

  // A pending read select replaces the conversion word in this frame.
  // Only one select belongs in a write; should a host set several, the
  // threshold beats gain and gain beats status, so the frame stays defined.
  always_comb begin
    priority case (1'b1)
      rdsel.read_threshold_select: next_frame = {threshold, 16'h0000};
      rdsel.read_gain_select: next_frame = {gain, 16'h0000};
      rdsel.read_status_select: next_frame = {status_word, 16'h0000};
      default: next_frame = {scaled, status_word[15:8]};
    endcase
  end

  // No frames while powered down; the registers still keep their values.
  assign frame_load = i_conv_valid & ~ctrl.power_down_request;

  // Shift out MSB first on falling serial edges while the strobe is high.
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      tx_shift <= '0;
      tx_count <= 6'h00;
      o_sdo <= 1'b0;
      o_output_frame_strobe <= 1'b0;
    end else if (frame_load) begin
      tx_shift <= {next_frame[FRAME_BITS-2:0], 1'b0};
      o_sdo <= next_frame[FRAME_BITS-1];
      tx_count <= 6'(FRAME_BITS - 1);
      o_output_frame_strobe <= 1'b1;
    end else if (o_output_frame_strobe && sclk_fall) begin
      if (tx_count == 6'h00) begin
        o_output_frame_strobe <= 1'b0;
        o_sdo <= 1'b0;
      end else begin
        o_sdo <= tx_shift[FRAME_BITS-1];
        tx_shift <= {tx_shift[FRAME_BITS-2:0], 1'b0};
        tx_count <= tx_count - 6'h01;
      end
    end
  end

endmodule

// ===== acs_host.sv
module acs_host (
  output logic o_sclk, // Serial clock to the block.
  output logic o_cs_n, // Write frame select, active low.
  output logic o_sdi, // Serial write data.
  input wire logic i_sdo // Serial read data.
);
  timeunit 1ns;
  timeprecision 1ps;
  // --------------------------------------------------------------
  // Host controller on the serial interface
  // --------------------------------------------------------------
  // The clock parks low between frames, as a real host would leave it.
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_sdi = 1'b0;
  end
  // Address word then data word, MSB first, one word per write.
  task automatic write(input logic [15:0] addr, input logic [15:0] data);
    logic [31:0] w;
    w = {addr, data};
    #13 o_cs_n = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      o_sdi = w[i];
      #80 o_sclk = 1'b1;
      #80 o_sclk = 1'b0;
    end
    #80 o_cs_n = 1'b1;
    o_sdi = ~o_sdi; // A released line must not keep showing the last bit.
    #200;
  endtask
  // Data moves on each falling edge, so it is taken just before the fall.
  task automatic read(output logic [31:0] f);
    for (int i = 31; i >= 0; i--) begin
      #80 o_sclk = 1'b1;
      #75 f[i] = i_sdo;
      #5 o_sclk = 1'b0;
    end
    #200;
  endtask
endmodule

// ===== acs_regs_chk.sv
module acs_regs_chk (
  input wire logic i_ref_clk, // Master clock.
  input wire logic i_nrst, // Reset, active low.
  input wire logic i_cs_n, // Write frame select.
  input wire logic i_conv_valid, // Conversion strobe.
  input wire logic i_stage1_valid, // First stage strobe.
  input wire logic i_mod_full_scale, // Modulator beyond full scale.
  input wire logic i_mod_tick, // Modulator rate strobe.
  input wire logic o_sdo, // Serial read data.
  input wire logic o_output_frame_strobe, // Output frame active.
  input wire logic o_ref_bypass, // Reference bypass.
  input wire logic o_power_down, // Power-down.
  input wire logic o_low_power, // Low power mode.
  input wire logic o_ref_buf_off, // Reference buffer off.
  input wire logic o_amplifier_disable, // Amplifier off.
  input wire logic o_filter_resync, // Resync pulse.
  input wire logic o_overrange_flag // Overrange alert.
);
  // --------------------------------------------------------------
  // Port relations
  // --------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);
  a_bypass_needs_off: assert property (o_ref_bypass |-> o_ref_buf_off)
    else $error("bypass while buffer on");
  a_resync_single: assert property ($rose(o_filter_resync) |=> !o_filter_resync)
    else $error("resync longer than one cycle");
  // Power-down output lags the stored bit by one cycle, hence the look one cycle on.
  a_frame_start: assert property (i_conv_valid ##1 !o_power_down |-> o_output_frame_strobe)
    else $error("no frame after conversion");
  a_pd_refuse: assert property
    (i_conv_valid && !o_output_frame_strobe ##1 o_power_down |-> !o_output_frame_strobe)
    else $error("frame during power-down");
  a_over_mod_run: assert property
    ((i_mod_tick && i_mod_full_scale)[*5] |-> ##2 o_overrange_flag)
    else $error("five full-scale ticks missed");
  a_over_cause: assert property
    ($rose(o_overrange_flag) |-> $past(i_stage1_valid, 2) || $past(i_mod_tick, 2))
    else $error("overrange without cause");
  a_sdo_idle: assert property (!o_output_frame_strobe |-> !o_sdo)
    else $error("data outside frame");
  a_ctrl_quiet: assert property (i_cs_n[*8] |-> $stable(o_amplifier_disable)
    && $stable(o_low_power) && $stable(o_power_down) && $stable(o_ref_buf_off))
    else $error("control moved with no write");
  c_frame: cover property ($rose(o_output_frame_strobe));
  c_resync: cover property (o_filter_resync);
  c_overrange: cover property ($rose(o_overrange_flag));
endmodule
bind acs_regs acs_regs_chk u_chk (.i_ref_clk, .i_nrst, .i_cs_n, .i_conv_valid, .i_stage1_valid,
  .i_mod_full_scale, .i_mod_tick, .o_sdo, .o_output_frame_strobe, .o_ref_bypass, .o_power_down,
  .o_low_power, .o_ref_buf_off, .o_amplifier_disable, .o_filter_resync, .o_overrange_flag);

// ===== adc_control_status_regs_bench.sv
module adc_control_status_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import acs_pkg::*;
  `define CHK(g, e, m) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("ERROR t=%0t %s got %h exp %h", $time, m, g, e); end end
  localparam logic PID = 1'b0; // Identity value, arbitrary.
  logic clk = 1'b0, nrst = 1'b0, sclk, cs_n, sdi, settled = 1'b0, cvld = 1'b0;
  logic s1v = 1'b0, mfs = 1'b0, mtk = 1'b0, sdo, fs, byp, pd, lp, bo, ao, rs, over_flag;
  logic [1:0] dec = 2'h0;
  logic [15:0] s1 = 16'h0000;
  logic [23:0] conv = 24'h000000;
  logic [31:0] f;
  int error_cnt = 0, n_checks = 0, rs_cnt = 0;
  // --------------------------------------------------------------
  // Clock, block and host
  // --------------------------------------------------------------
  always #10 clk = ~clk;
  always @(posedge clk) if (rs) rs_cnt++;
  acs_regs #(.PART_ID_BIT(PID)) uut (.i_ref_clk(clk), .i_nrst(nrst), .i_sclk(sclk),
    .i_cs_n(cs_n), .i_sdi(sdi), .i_ratio_code(dec), .i_settled(settled), .i_conv_data(conv),
    .i_conv_valid(cvld), .i_stage1_mag(s1), .i_stage1_valid(s1v), .i_mod_full_scale(mfs),
    .i_mod_tick(mtk), .o_sdo(sdo), .o_output_frame_strobe(fs), .o_ref_bypass(byp),
    .o_power_down(pd), .o_low_power(lp), .o_ref_buf_off(bo), .o_amplifier_disable(ao),
    .o_filter_resync(rs), .o_overrange_flag(over_flag));
  acs_host host (.o_sclk(sclk), .o_cs_n(cs_n), .o_sdi(sdi), .i_sdo(sdo));
  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  task automatic cyc(int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic conv_go(logic [23:0] d);
    @(negedge clk);
    conv = d;
    cvld = 1'b1;
    @(negedge clk);
    cvld = 1'b0;
  endtask
  // Select a register for the next frame, start the frame and collect it.
  task automatic rd(logic [15:0] ctl);
    host.write(ADDR_CONTROL, ctl);
    conv_go(24'h000000);
    host.read(f);
    `CHK(fs, 1'b0, "frame end");
  endtask
  task automatic outs(logic [4:0] e, string m);
    `CHK({byp, pd, lp, bo, ao}, e, m);
  endtask
  function automatic logic [15:0] st(logic l, logic b, logic a);
    return {PID, STAT_FIXED_HI, settled, l, 1'b0, STAT_FIXED_MID, b, a, STAT_FIXED_LO, dec};
  endfunction
  task automatic stage(logic [15:0] m);
    @(negedge clk);
    s1 = m;
    s1v = 1'b1;
    @(negedge clk);
    s1v = 1'b0;
    cyc(2);
  endtask
  // Back-to-back modulator ticks; the flag needs two cycles to show.
  task automatic ticks(int n, logic v);
    repeat (n) begin
      @(negedge clk);
      mtk = 1'b1;
      mfs = v;
    end
    @(negedge clk);
    mtk = 1'b0;
    cyc(2);
  endtask
  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic t_reset;
    outs(5'h00, "reset outputs");
    rd(16'h2000);
    `CHK(f, {RST_GAIN, 16'h0000}, "gain reset");
    rd(16'h4000);
    `CHK(f, {RST_THRESHOLD, 16'h0000}, "threshold reset");
    $display("test reset done");
  endtask
  task automatic t_ctrl;
    host.write(ADDR_CONTROL, 16'h1574);
    outs(5'h04, "fixed zeros");
    host.write(ADDR_CONTROL, 16'h0080);
    outs(5'h00, "bypass with buffer on");
    host.write(ADDR_CONTROL, 16'h0083);
    outs(5'h13, "bypass with buffer off");
    host.write(ADDR_CONTROL, 16'h0000);
    host.write(16'h0003, 16'h0008);
    outs(5'h00, "unmapped write");
    $display("test ctrl done");
  endtask
  task automatic t_status;
    logic x;
    for (int d = 0; d < 4; d++) begin
      x = (d == 3);
      @(negedge clk);
      dec = 2'(d);
      settled = x;
      rd(x ? 16'h0807 : 16'h0800);
      `CHK(f[31:16], st(x, x, x), "status");
    end
    outs(5'h07, "status outputs");
    $display("test status done");
  endtask
  task automatic t_pd;
    logic [15:0] s;
    host.write(ADDR_GAIN, 16'h8000);
    host.write(ADDR_CONTROL, 16'h0008);
    `CHK(pd, 1'b1, "power down");
    conv_go(24'h123456);
    cyc(2);
    `CHK(fs, 1'b0, "no frame when down");
    rd(16'h2000);
    `CHK(f, 32'h80000000, "gain kept");
    s = st(1'b0, 1'b0, 1'b0);
    conv_go(24'h123456);
    host.read(f);
    `CHK(f, {24'h123456, s[15:8]}, "conversion frame");
    $display("test power done");
  endtask
  task automatic t_resync;
    rs_cnt = 0;
    host.write(ADDR_CONTROL, 16'h0200);
    host.write(ADDR_CONTROL, 16'h0000);
    `CHK(rs_cnt, 1, "one resync pulse");
    $display("test resync done");
  endtask
  task automatic t_overrange;
    host.write(ADDR_GAIN, 16'h4000);
    host.write(ADDR_THRESHOLD, 16'h1000);
    stage(16'h1000);
    `CHK(over_flag, 1'b0, "at threshold");
    stage(16'h1001);
    `CHK(over_flag, 1'b1, "above threshold");
    stage(16'h0000);
    ticks(4, 1'b1);
    `CHK(over_flag, 1'b0, "four ticks");
    ticks(1, 1'b0);
    ticks(5, 1'b1);
    `CHK(over_flag, 1'b1, "five ticks");
    // No tick arrives during the read, so the flag still stands in the status word.
    rd(16'h0800);
    `CHK(f[24], 1'b1, "status overrange bit");
    ticks(1, 1'b0);
    `CHK(over_flag, 1'b0, "flag cleared");
    $display("test overrange done");
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    cyc(6);
    nrst = 1'b1;
    cyc(4);
    t_reset;
    t_ctrl;
    t_status;
    t_pd;
    t_resync;
    t_overrange;
    print_verdict;
  end
  // The tests need some 160 us; this cuts a hang well beyond that.
  initial begin
    #1ms;
    error_cnt++;
    $display("ERROR t=%0t watchdog expired", $time);
    print_verdict;
  end
endmodule
